// ===== hdl/qbp_pkg.sv
// Function
// - first general port bits reset to one, held only by weak pullup
// - third general port bits reset to one, held only by weak pullup
// - upper-address port resets to weak-pullup high, acting as plain i/o
// - latch at one means input; pin level is read back from outside
// - writing zero turns on strong pulldown until one written or reset
// - writing one over a zero fires a brief strong pull-high driver
// - after that pulse a weak sustaining pullup takes over
// - after the pulse the pin is output-high and readable input again
// - first port bit 0 is timer three i/o, bit 1 its trigger
// - first port bits 2 and 3 carry second serial receive and transmit
// - first port bits 4 and 6 interrupt on rising edge
// - first port bits 5 and 7 interrupt on falling edge
// - upper-address port drives high address byte during external accesses
// - page mode one puts high and low address bytes on upper port
// - page mode two multiplexes high address byte with data byte
// - third port offers interrupt, serial, timer and strobe functions
// - third port map: rx, tx, irq0, irq1, t0, t1, write, read
package qbp_pkg;
   localparam int unsigned PORT_W = 8;
   localparam int unsigned PULSE_CYC_DEF = 1;
   // first port bit positions
   localparam int unsigned P1_T3IO = 0;
   localparam int unsigned P1_T3TRG = 1;
   localparam int unsigned P1_RX2 = 2;
   localparam int unsigned P1_TX2 = 3;
   localparam int unsigned P1_IRA = 4;
   localparam int unsigned P1_IFA = 5;
   localparam int unsigned P1_IRB = 6;
   localparam int unsigned P1_IFB = 7;
   // third port bit positions
   localparam int unsigned P3_RX0 = 0;
   localparam int unsigned P3_TX0 = 1;
   localparam int unsigned P3_IRQ0 = 2;
   localparam int unsigned P3_IRQ1 = 3;
   localparam int unsigned P3_T0 = 4;
   localparam int unsigned P3_T1 = 5;
   localparam int unsigned P3_WR = 6;
   localparam int unsigned P3_RD = 7;
   localparam logic [7:0] LATCH_RST = 8'hFF;
   typedef enum logic [1:0] {
      QBP_MODE_NORMAL = 2'h0,
      QBP_MODE_PAGE1 = 2'h1,
      QBP_MODE_PAGE2 = 2'h3
   } qbp_mode_e;
   typedef enum logic [1:0] {
      QBP_PH_ADDR = 2'h0,
      QBP_PH_LOW = 2'h1,
      QBP_PH_DATA = 2'h3
   } qbp_phase_e;
   // pad drive of one port
   typedef struct packed {
      logic [7:0] pull_dn;
      logic [7:0] strong_up;
      logic [7:0] weak_up;
   } qbp_drive_s;
   // external bus request from the core
   typedef struct packed {
      logic active;
      qbp_mode_e mode;
      qbp_phase_e phase;
      logic [15:0] addr;
      logic [7:0] data;
   } qbp_bus_s;
endpackage

// ===== hdl/qbp_bit.sv
`timescale 1ns/10ps
`default_nettype none
// one quasi-bidirectional pad bit
module qbp_bit #(
   parameter int unsigned PULSE_CYC = qbp_pkg::PULSE_CYC_DEF
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic level_i,
   output logic pull_dn_o,
   output logic strong_up_o,
   output logic weak_up_o
);
   localparam int unsigned CW = (PULSE_CYC < 2) ? 1 : $clog2(PULSE_CYC + 1);
   logic lvl_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   wire logic rise;

   if (PULSE_CYC < 1) begin : g_bad_pulse
      $error("pulse length must be at least one cycle");
   end

   assign rise = level_i & ~lvl_q;
   // pulse counter, reloaded on a zero-to-one write; a new zero cuts it so
   // the strong driver never fights the pulldown
   assign cnt_d = rise ? CW'(PULSE_CYC)
      : (!level_i ? '0 : ((cnt_q != '0) ? cnt_q - CW'(1) : cnt_q));

   // the strong driver is registered, so it starts one clock after the latch rises
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lvl_q <= 1'b1;
         cnt_q <= '0;
         pull_dn_o <= 1'b0;
         strong_up_o <= 1'b0;
         weak_up_o <= 1'b1;
      end else begin
         lvl_q <= level_i;
         cnt_q <= cnt_d;
         pull_dn_o <= ~level_i;
         strong_up_o <= level_i & (cnt_d != '0);
         weak_up_o <= level_i;
      end
   end

   a_pulse_len: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(strong_up_o) |-> strong_up_o [*1] ##PULSE_CYC !strong_up_o)
      else $error("strong driver pulse length wrong");
   a_no_fight: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      pull_dn_o |-> !strong_up_o && !weak_up_o)
      else $error("pulldown while pulling up");
endmodule
`default_nettype wire

// ===== hdl/qbp_ports.sv
`timescale 1ns/10ps
`default_nettype none
module qbp_ports #(
   parameter int unsigned PULSE_CYC = qbp_pkg::PULSE_CYC_DEF
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // software port latch writes, one-cycle strobes
   input wire logic p1_wr_i,
   input wire logic p2_wr_i,
   input wire logic p3_wr_i,
   input wire logic [7:0] wr_data_i,
   // alternate-function outputs from peripherals, one means release
   input wire logic timer_three_ext_io_i,
   input wire logic second_serial_transmit_i,
   input wire logic first_serial_transmit_i,
   input wire logic wr_strobe_n_i,
   input wire logic rd_strobe_n_i,
   input wire qbp_pkg::qbp_bus_s bus_i,
   // pad levels
   input wire logic [7:0] p1_pin_i,
   input wire logic [7:0] p2_pin_i,
   input wire logic [7:0] p3_pin_i,
   output var qbp_pkg::qbp_drive_s p1_drv_o,
   output var qbp_pkg::qbp_drive_s p2_drv_o,
   output var qbp_pkg::qbp_drive_s p3_drv_o,
   // synchronised pin reads
   output logic [7:0] p1_rd_o,
   output logic [7:0] p2_rd_o,
   output logic [7:0] p3_rd_o,
   output logic timer_three_ext_io_o,
   output logic timer_three_capture_trigger_o,
   output logic second_serial_receive_o,
   output logic first_serial_receive_o,
   output logic ext_irq_zero_o,
   output logic ext_irq_one_o,
   output logic timer_zero_ext_input_o,
   output logic timer_one_ext_input_o,
   // edge-detect interrupt pulses, one cycle
   output logic ext_irq_rise_a_o,
   output logic ext_irq_fall_a_o,
   output logic ext_irq_rise_b_o,
   output logic ext_irq_fall_b_o
);
   localparam int unsigned W = qbp_pkg::PORT_W;

   // ****************************************
   // latches and input synchronisers
   // ****************************************
   logic [W-1:0] p1_lat_q;
   logic [W-1:0] p2_lat_q;
   logic [W-1:0] p3_lat_q;
   logic [3*W-1:0] meta_q;
   logic [3*W-1:0] sync_q;
   logic [W-1:0] p1_old_q;

   // latches come up at all ones so every pin is a weak-pullup input
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p1_lat_q <= qbp_pkg::LATCH_RST;
         p2_lat_q <= qbp_pkg::LATCH_RST;
         p3_lat_q <= qbp_pkg::LATCH_RST;
      end else begin
         if (p1_wr_i) p1_lat_q <= wr_data_i;
         if (p2_wr_i) p2_lat_q <= wr_data_i;
         if (p3_wr_i) p3_lat_q <= wr_data_i;
      end
   end

   // two flops before any logic sees a pad; meta_q read only by sync_q
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= '1;
         sync_q <= '1;
         p1_old_q <= '1;
      end else begin
         meta_q <= {p3_pin_i, p2_pin_i, p1_pin_i};
         sync_q <= meta_q;
         p1_old_q <= sync_q[W-1:0];
      end
   end

   // ****************************************
   // effective output levels
   // ****************************************
   wire logic [W-1:0] p1_alt;
   wire logic [W-1:0] p3_alt;
   wire logic [W-1:0] p1_lvl;
   wire logic [W-1:0] p3_lvl;
   wire logic [W-1:0] p2_lvl;
   wire logic [W-1:0] p2_bus;

   // alternate outputs AND with the latch: latch must be one to let them through
   // second serial transmit gates bit 3
   assign p1_alt = {4'hF, second_serial_transmit_i, 3'h7};
   assign p1_lvl = p1_lat_q & p1_alt & {{(W-1){1'b1}}, timer_three_ext_io_i};
   assign p3_alt = {rd_strobe_n_i, wr_strobe_n_i, 4'hF, first_serial_transmit_i, 1'b1};
   assign p3_lvl = p3_lat_q & p3_alt;

   // high byte in every mode; low byte or data in page phases
   assign p2_bus = (bus_i.mode == qbp_pkg::QBP_MODE_PAGE1 && bus_i.phase == qbp_pkg::QBP_PH_LOW)
      ? bus_i.addr[7:0]
      : (bus_i.mode == qbp_pkg::QBP_MODE_PAGE2 && bus_i.phase == qbp_pkg::QBP_PH_DATA)
      ? bus_i.data
      : bus_i.addr[15:8];
   assign p2_lvl = bus_i.active ? p2_bus : p2_lat_q;

   // ****************************************
   // pad bit cells
   // ****************************************
   wire logic [3*W-1:0] lvl_all;
   wire logic [3*W-1:0] dn_all;
   wire logic [3*W-1:0] su_all;
   wire logic [3*W-1:0] wu_all;
   assign lvl_all = {p3_lvl, p2_lvl, p1_lvl};

   genvar gi;
   generate
      for (gi = 0; gi < 3 * W; gi++) begin : g_bit
         qbp_bit #(.PULSE_CYC(PULSE_CYC)) u_bit (
            .sys_clk_i(sys_clk_i),
            .reset_n_i(reset_n_i),
            .level_i(lvl_all[gi]),
            .pull_dn_o(dn_all[gi]),
            .strong_up_o(su_all[gi]),
            .weak_up_o(wu_all[gi])
         );
      end
   endgenerate

   assign p1_drv_o = '{pull_dn: dn_all[W-1:0], strong_up: su_all[W-1:0],
      weak_up: wu_all[W-1:0]};
   assign p2_drv_o = '{pull_dn: dn_all[2*W-1:W], strong_up: su_all[2*W-1:W],
      weak_up: wu_all[2*W-1:W]};
   assign p3_drv_o = '{pull_dn: dn_all[3*W-1:2*W], strong_up: su_all[3*W-1:2*W],
      weak_up: wu_all[3*W-1:2*W]};

   // ****************************************
   // read-back and alternate inputs
   // ****************************************
   wire logic [W-1:0] s1;
   wire logic [W-1:0] s3;
   assign s1 = sync_q[W-1:0];
   assign s3 = sync_q[3*W-1:2*W];

   // reads show the real pin, so an outside driver beats the weak pullup
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p1_rd_o <= qbp_pkg::LATCH_RST;
         p2_rd_o <= qbp_pkg::LATCH_RST;
         p3_rd_o <= qbp_pkg::LATCH_RST;
         timer_three_ext_io_o <= 1'b1;
         timer_three_capture_trigger_o <= 1'b1;
         second_serial_receive_o <= 1'b1;
         first_serial_receive_o <= 1'b1;
         ext_irq_zero_o <= 1'b1;
         ext_irq_one_o <= 1'b1;
         timer_zero_ext_input_o <= 1'b1;
         timer_one_ext_input_o <= 1'b1;
         ext_irq_rise_a_o <= 1'b0;
         ext_irq_fall_a_o <= 1'b0;
         ext_irq_rise_b_o <= 1'b0;
         ext_irq_fall_b_o <= 1'b0;
      end else begin
         p1_rd_o <= s1;
         p2_rd_o <= sync_q[2*W-1:W];
         p3_rd_o <= s3;
         timer_three_ext_io_o <= s1[qbp_pkg::P1_T3IO];
         timer_three_capture_trigger_o <= s1[qbp_pkg::P1_T3TRG];
         second_serial_receive_o <= s1[qbp_pkg::P1_RX2];
         first_serial_receive_o <= s3[qbp_pkg::P3_RX0];
         ext_irq_zero_o <= s3[qbp_pkg::P3_IRQ0];
         ext_irq_one_o <= s3[qbp_pkg::P3_IRQ1];
         timer_zero_ext_input_o <= s3[qbp_pkg::P3_T0];
         timer_one_ext_input_o <= s3[qbp_pkg::P3_T1];
         ext_irq_rise_a_o <= s1[qbp_pkg::P1_IRA] & ~p1_old_q[qbp_pkg::P1_IRA];
         ext_irq_fall_a_o <= ~s1[qbp_pkg::P1_IFA] & p1_old_q[qbp_pkg::P1_IFA];
         ext_irq_rise_b_o <= s1[qbp_pkg::P1_IRB] & ~p1_old_q[qbp_pkg::P1_IRB];
         ext_irq_fall_b_o <= ~s1[qbp_pkg::P1_IFB] & p1_old_q[qbp_pkg::P1_IFB];
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_rise_edge: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      ext_irq_rise_a_o |-> $past(s1[qbp_pkg::P1_IRA]) && !$past(p1_old_q[qbp_pkg::P1_IRA]))
      else $error("rising interrupt without edge");
   a_fall_edge: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (!s1[qbp_pkg::P1_IFB] && p1_old_q[qbp_pkg::P1_IFB]) |=> ext_irq_fall_b_o)
      else $error("falling edge missed");
   a_zero_holds: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (p1_wr_i && !wr_data_i[qbp_pkg::P1_IRA]) |=> ##1 p1_drv_o.pull_dn[qbp_pkg::P1_IRA])
      else $error("pulldown not on after zero write");
   a_one_pulse: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (p3_wr_i && wr_data_i[qbp_pkg::P3_T0] && !p3_lat_q[qbp_pkg::P3_T0])
      |=> ##1 p3_drv_o.strong_up[qbp_pkg::P3_T0] && p3_drv_o.weak_up[qbp_pkg::P3_T0])
      else $error("no strong pulse after one over zero");
   a_read_pin: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      ##3 1'b1 |-> p2_rd_o == $past(p2_pin_i, 3))
      else $error("read-back is not the pin level");
   a_page2_data: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (bus_i.active && bus_i.mode == qbp_pkg::QBP_MODE_PAGE2 && bus_i.phase ==
      qbp_pkg::QBP_PH_DATA && bus_i.data[0] == 1'b0) |=> p2_drv_o.pull_dn[0])
      else $error("page two data not driven");
endmodule
`default_nettype wire

// ===== tb/qbp_board.sv
`timescale 1ns/10ps
`default_nettype none
// ************
// board model
// ************
// one port of pads, outside drivers and pullups
module qbp_board (
   input wire qbp_pkg::qbp_drive_s drv_i,
   input wire logic [7:0] ext_en_i,
   input wire logic [7:0] ext_val_i,
   output logic [7:0] pin_o
);
   // pulldown wins, outside driver beats the weak pullup, else pin floats high
   assign pin_o = ~drv_i.pull_dn & ((ext_en_i & ext_val_i) | ~ext_en_i);
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ************
// port pin bench
// ************
module testbench;
   localparam int PULSE = 2;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [2:0] wr = 3'h0;
   logic [7:0] wd = 8'h00;
   logic t3 = 1'b1, tx2 = 1'b1, tx0 = 1'b1, wrn = 1'b1, rdn = 1'b1;
   qbp_pkg::qbp_bus_s bus = '0;
   logic [7:0] lat [3] = '{8'hFF, 8'hFF, 8'hFF};
   logic [7:0] en [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] ev [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] pin [3];
   logic [7:0] rd [3];
   qbp_pkg::qbp_drive_s drv [3];
   logic [7:0] alt;
   logic [3:0] irq;
   int n_errors = 0, comparisons = 0, cyc = 0, seed = 3802;
   int nra = 0, nfa = 0, nrb = 0, nfb = 0, hits;
   int s_ra = 0, s_fa = 0, s_rb = 0, s_fb = 0;
   qbp_pkg::qbp_mode_e modes [3] = '{qbp_pkg::QBP_MODE_NORMAL, qbp_pkg::QBP_MODE_PAGE1,
      qbp_pkg::QBP_MODE_PAGE2};
   qbp_pkg::qbp_phase_e phs [3] = '{qbp_pkg::QBP_PH_ADDR, qbp_pkg::QBP_PH_LOW,
      qbp_pkg::QBP_PH_DATA};

   always #5 sys_clk_i = ~sys_clk_i;

   qbp_ports #(.PULSE_CYC(PULSE)) u_qbp_ports (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .p1_wr_i(wr[0]), .p2_wr_i(wr[1]), .p3_wr_i(wr[2]), .wr_data_i(wd),
      .timer_three_ext_io_i(t3), .second_serial_transmit_i(tx2),
      .first_serial_transmit_i(tx0), .wr_strobe_n_i(wrn), .rd_strobe_n_i(rdn), .bus_i(bus),
      .p1_pin_i(pin[0]), .p2_pin_i(pin[1]), .p3_pin_i(pin[2]),
      .p1_drv_o(drv[0]), .p2_drv_o(drv[1]), .p3_drv_o(drv[2]),
      .p1_rd_o(rd[0]), .p2_rd_o(rd[1]), .p3_rd_o(rd[2]),
      .timer_three_ext_io_o(alt[0]), .timer_three_capture_trigger_o(alt[1]),
      .second_serial_receive_o(alt[2]), .first_serial_receive_o(alt[3]),
      .ext_irq_zero_o(alt[4]), .ext_irq_one_o(alt[5]),
      .timer_zero_ext_input_o(alt[6]), .timer_one_ext_input_o(alt[7]),
      .ext_irq_rise_a_o(irq[0]), .ext_irq_fall_a_o(irq[1]),
      .ext_irq_rise_b_o(irq[2]), .ext_irq_fall_b_o(irq[3]));

   // three boards, one per port
   for (genvar g = 0; g < 3; g++) begin : g_brd
      qbp_board u_qbp_board (.drv_i(drv[g]), .ext_en_i(en[g]), .ext_val_i(ev[g]),
         .pin_o(pin[g]));
   end

   // pulse counters; a pulse lasting two cycles counts twice
   always @(posedge sys_clk_i) begin
      nra <= nra + int'(irq[0]);
      nfa <= nfa + int'(irq[1]);
      nrb <= nrb + int'(irq[2]);
      nfb <= nfb + int'(irq[3]);
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // level the pad cell should hold: latch gated by alt outputs or bus byte
   function automatic logic [7:0] eff(int p);
      logic [7:0] e;
      e = lat[p];
      if (p == 0) e = e & {4'hF, tx2, 2'h3, t3};
      if (p == 2) e = e & {rdn, wrn, 4'hF, tx0, 1'b1};
      if (p == 1 && bus.active) begin
         e = bus.addr[15:8];
         if (bus.mode == qbp_pkg::QBP_MODE_PAGE1 && bus.phase == qbp_pkg::QBP_PH_LOW)
            e = bus.addr[7:0];
         if (bus.mode == qbp_pkg::QBP_MODE_PAGE2 && bus.phase == qbp_pkg::QBP_PH_DATA)
            e = bus.data;
      end
      return e;
   endfunction

   function automatic logic [7:0] pexp(int p);
      return eff(p) & ((en[p] & ev[p]) | ~en[p]);
   endfunction

   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic waitn(int n);
      repeat (n) @(negedge sys_clk_i);
   endtask

   task automatic wrp(int p, logic [7:0] d);
      @(negedge sys_clk_i);
      wr[p] = 1'b1;
      wd = d;
      lat[p] = d;
      @(negedge sys_clk_i);
      wr[p] = 1'b0;
   endtask

   // steady-state comparison of every port against the model
   task automatic check_all();
      logic [7:0] a;
      logic [7:0] c;
      for (int p = 0; p < 3; p++) begin
         chk("pull_dn", drv[p].pull_dn, ~eff(p));
         chk("weak_up", drv[p].weak_up, eff(p));
         chk("strong_up", drv[p].strong_up, 8'h00);
         chk("pin_read", rd[p], pexp(p));
      end
      a = pexp(0);
      c = pexp(2);
      chk("alt_in", alt, {c[5], c[4], c[3], c[2], c[0], a[2], a[1], a[0]});
   endtask

   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      waitn(5);
      reset_n_i = 1'b1;
      waitn(1);
      check_all();
      // random latch writes, alt levels and outside drivers
      for (int i = 0; i < 30; i++) begin
         {t3, tx2, tx0, wrn, rdn} = 5'($random(seed));
         for (int p = 0; p < 3; p++) begin
            en[p] = 8'($random(seed));
            ev[p] = 8'($random(seed));
         end
         wrp(i % 3, 8'($random(seed)));
         waitn(6);
         check_all();
      end
      // strong pulse only on bits rising from zero
      {t3, tx2, tx0, wrn, rdn} = 5'h1F;
      en = '{8'h00, 8'h00, 8'h00};
      wrp(0, 8'h0F);
      waitn(4);
      wrp(0, 8'hFF);
      hits = 0;
      for (int k = 0; k < 8; k++) begin
         waitn(1);
         if (drv[0].strong_up === 8'hF0 && drv[0].weak_up === 8'hFF) hits++;
      end
      chk("pulse_len", 8'(hits), 8'(PULSE));
      check_all();
      // edges on the four interrupt pins
      en[0] = 8'hF0;
      ev[0] = 8'h00;
      waitn(6);
      {s_ra, s_fa, s_rb, s_fb} = {nra, nfa, nrb, nfb};
      ev[0] = 8'hF0;
      waitn(6);
      chk("irq_rise", {2'(nra - s_ra), 2'(nfa - s_fa), 2'(nrb - s_rb), 2'(nfb - s_fb)}, 8'h44);
      ev[0] = 8'h00;
      waitn(6);
      chk("irq_fall", {2'(nra - s_ra), 2'(nfa - s_fa), 2'(nrb - s_rb), 2'(nfb - s_fb)}, 8'h55);
      // every bus mode with every phase
      for (int m = 0; m < 3; m++) begin
         for (int h = 0; h < 3; h++) begin
            bus = {1'b1, modes[m], phs[h], 16'($random(seed)), 8'($random(seed))};
            waitn(6);
            check_all();
         end
      end
      bus.active = 1'b0;
      waitn(6);
      check_all();
      report_and_stop();
   end
endmodule
`default_nettype wire
